/* verilog/usm_master.sv */
// universal spi master engine: transmit and receive fifos, bit timing,
// chip selects and status. assumes configuration inputs come from
// registers on ref_clk; miso_in is an asynchronous pin.
`timescale 1ns/1ps
// What this block does
// - fixed-length beat shifts one to thirty-two bits
// - variable-length beat shifts one to thirty-one bits, length per word
// - three independent chip-select outputs
// - transmit and receive fifos of four 32-bit words
// - output-change edge and input-sample edge selectable independently
// - serial clock idle level selectable high or low
// - shifting starts at most or least significant bit
// - chip select falls one and a half bit-times before first clock edge
// - one unchanged half-bit follows the last clock edge
// - optional extra half-bit hold at transfer end
// - chip select high at least one bit-time, plus zero to seven more
// - serial clock is system clock over twice (speed plus one)
// - data-out hold extended by zero, one, four or seven clocks
// - transmit-empty flag rises when the last word is popped
// - receive level reports exact words held
// - no receive-full interrupt; receive never outnumbers transmit
// - idle flag needs empty transmit fifo and all actions done
// - each burst carries at most thirty-two bits
// - continuing-address word keeps chip select asserted afterwards
// - ending-address word releases chip select after its burst
// - divider held in a twelve-bit speed field
// - variable word: bits 28:24 length, 23:0 data, msb from 23
// - variable chip-select word (with variable width only): bits 31:29 give the pattern
// - hold code 00/01/10/11 means 0/1/4/7 clocks
module usm_master #(
   parameter int unsigned DEPTH = usm_pkg::FIFO_DEPTH
) (
   input  wire logic                        ref_clk,
   input  wire logic                        arst_n,
   input  wire logic                        enable,
   input  wire logic [usm_pkg::SPEED_W-1:0] speed,
   input  wire logic [2:0]                  cs_pattern,
   input  wire logic                        post_input,
   input  wire logic                        var_cs,
   input  wire logic                        var_width,
   input  wire logic [1:0]                  hold_sel,
   input  wire logic                        in_rising,
   input  wire logic                        clear_fifos,
   input  wire logic                        out_rising,
   input  wire logic                        clk_idle_high,
   input  wire logic                        msb_first,
   input  wire logic [usm_pkg::LEN_W-1:0]   shift_len,
   input  wire logic [2:0]                  cs_high_extra,
   input  wire logic                        tx_push,
   input  wire logic                        tx_keep_cs,
   input  wire logic [usm_pkg::DATA_W-1:0]  tx_data,
   input  wire logic                        rx_pop,
   input  wire logic                        miso_in,
   output logic                             tx_full,
   output logic [usm_pkg::LVL_W-1:0]        tx_level,
   output logic [usm_pkg::DATA_W-1:0]       rx_data,
   output logic                             rx_empty,
   output logic [usm_pkg::LVL_W-1:0]        rx_level,
   output logic                             tx_empty_irq,
   output logic                             idle_irq,
   output logic                             serial_clock_out,
   output logic                             mosi_out,
   output logic [2:0]                       cs_n_out
);
   localparam int unsigned DW = usm_pkg::DATA_W;

   usm_pkg::usm_state_t state_q;
   logic [DW:0]                  tx_head;
   logic                         tx_empty;
   logic                         rx_full;
   logic                         tx_pop;
   logic                         rx_push;
   logic [DW-1:0]                rx_word;
   logic                         tick;
   logic                         run;
   logic [DW-1:0]                word_q;
   logic                         keep_q;
   logic [usm_pkg::LEN_W-1:0]    len_q;
   logic [usm_pkg::EDGE_W-1:0]   edge_q;
   logic [3:0]                   half_q;
   logic                         phase_q;
   logic                         first_q;
   logic [DW-1:0]                tx_sh_q;
   logic [DW-1:0]                rx_sh_q;
   logic                         pend_q;
   logic [2:0]                   hcnt_q;
   logic                         miso_meta_q;
   logic                         miso_q;
   logic                         rising;
   logic                         in_edge;
   logic                         out_edge;
   logic                         last_edge;
   logic                         finish;
   logic                         sample;
   logic                         next_bit;

   // length per word, clamped to at least one bit
   function automatic logic [usm_pkg::LEN_W-1:0] eff_len(input logic [DW-1:0] w,
                                                        input logic var_w,
                                                        input logic [5:0] fixed);
      logic [usm_pkg::LEN_W-1:0] l;
      l = var_w ? usm_pkg::LEN_W'(w[usm_pkg::VLEN_HI:usm_pkg::VLEN_LO]) : fixed;
      if (l == '0)
         l = usm_pkg::LEN_MIN;
      else if (l > usm_pkg::LEN_FULL)
         l = usm_pkg::LEN_FULL;
      return l;
   endfunction : eff_len

   function automatic logic [2:0] hold_cycles(input logic [1:0] code);
      logic [2:0] h;
      unique case (code)
         2'h0: h = usm_pkg::HOLD_C0;
         2'h1: h = usm_pkg::HOLD_C1;
         2'h2: h = usm_pkg::HOLD_C2;
         2'h3: h = usm_pkg::HOLD_C3;
      endcase
      return h;
   endfunction : hold_cycles

   // transmit fifo carries the keep-cs tag beside each word
   usm_fifo #(
      .WIDTH (DW + 1),
      .DEPTH (DEPTH),
      .AW    (usm_pkg::FIFO_AW),
      .LW    (usm_pkg::LVL_W)
   ) u_tx_fifo (
      .clk       (ref_clk),
      .arst_n    (arst_n),
      .flush     (clear_fifos),
      .push      (tx_push),
      .wr_data   ({tx_keep_cs, tx_data}),
      .pop       (tx_pop),
      .rd_data_q (tx_head),
      .empty_q   (tx_empty),
      .full_q    (tx_full),
      .count_q   (tx_level)
   );

   // receive fifo level is its own exact count
   usm_fifo #(
      .WIDTH (DW),
      .DEPTH (DEPTH),
      .AW    (usm_pkg::FIFO_AW),
      .LW    (usm_pkg::LVL_W)
   ) u_rx_fifo (
      .clk       (ref_clk),
      .arst_n    (arst_n),
      .flush     (clear_fifos),
      .push      (rx_push),
      .wr_data   (rx_word),
      .pop       (rx_pop),
      .rd_data_q (rx_data),
      .empty_q   (rx_empty),
      .full_q    (rx_full),
      .count_q   (rx_level)
   );

   assign run = (state_q != usm_pkg::USM_IDLE) && (state_q != usm_pkg::USM_LOAD);
   usm_tick #(
      .W (usm_pkg::SPEED_W)
   ) u_tick (
      .clk    (ref_clk),
      .arst_n (arst_n),
      .run    (run),
      .div    (speed),
      .tick_q (tick)
   );

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         miso_meta_q <= 1'b0;
         miso_q      <= 1'b0;
      end
      else
      begin
         miso_meta_q <= miso_in;
         miso_q      <= miso_meta_q;
      end
   end

   // edge direction from the physical clock level about to appear
   assign rising    = (~phase_q) ^ clk_idle_high;
   assign in_edge   = tick && (state_q == usm_pkg::USM_SHIFT) && (rising == in_rising);
   assign out_edge  = tick && (state_q == usm_pkg::USM_SHIFT) && (rising == out_rising)
                      && (edge_q != '0);
   assign last_edge = (edge_q == usm_pkg::EDGE_W'({len_q, 1'b0} - 1'b1));
   // a transfer starts only while enabled
   assign tx_pop    = (state_q == usm_pkg::USM_IDLE) && enable && !tx_empty && !clear_fifos;
   assign finish    = tick && ((state_q == usm_pkg::USM_HOLD) ||
                      ((state_q == usm_pkg::USM_TAIL) && !post_input));
   // post-input skips the first sample and takes a dangling one
   assign sample    = (in_edge && !(post_input && first_q)) ||
                      (tick && (state_q == usm_pkg::USM_HOLD));
   // one receive push per burst unless the receive fifo is full, in pop order
   assign rx_push   = finish && !rx_full;
   assign rx_word   = msb_first ? rx_sh_q : rx_sh_q >> (usm_pkg::LEN_FULL - len_q);
   assign next_bit  = msb_first ? tx_sh_q[DW-2] : tx_sh_q[1];

   // sequencer
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         state_q <= usm_pkg::USM_IDLE;
      else
      begin
         unique case (state_q)
            usm_pkg::USM_IDLE:
               if (tx_pop)
                  state_q <= usm_pkg::USM_LOAD;
            usm_pkg::USM_LOAD:
               state_q <= usm_pkg::USM_SETUP;
            // one full bit with chip select low before clocking
            usm_pkg::USM_SETUP:
               if (tick && half_q == usm_pkg::HALVES_BIT - 1'b1)
                  state_q <= usm_pkg::USM_SHIFT;
            usm_pkg::USM_SHIFT:
               if (tick && last_edge)
                  state_q <= usm_pkg::USM_TAIL;
            // unchanged half-bit after the last edge
            usm_pkg::USM_TAIL:
               if (tick)
                  state_q <= post_input ? usm_pkg::USM_HOLD :
                             keep_q ? usm_pkg::USM_IDLE : usm_pkg::USM_CSHIGH;
            usm_pkg::USM_HOLD:
               if (tick)
                  state_q <= keep_q ? usm_pkg::USM_IDLE : usm_pkg::USM_CSHIGH;
            // chip select high for one bit plus extra bit-times
            usm_pkg::USM_CSHIGH:
               if (tick && half_q == usm_pkg::HALVES_BIT + {cs_high_extra, 1'b0} - 1'b1)
                  state_q <= usm_pkg::USM_IDLE;
            default:
               state_q <= usm_pkg::USM_IDLE;
         endcase
      end
   end

   // half-bit counter, counts ticks in setup and chip-select high, cleared in other states
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         half_q <= '0;
      else if (!run || (tick && state_q != usm_pkg::USM_SETUP &&
                        state_q != usm_pkg::USM_CSHIGH))
         half_q <= '0;
      else if (tick && state_q == usm_pkg::USM_SETUP && half_q == usm_pkg::HALVES_BIT - 1'b1)
         half_q <= '0;
      else if (tick)
         half_q <= half_q + 1'b1;
   end

   // word capture and per-burst settings
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         word_q <= '0;
         keep_q <= 1'b0;
         len_q  <= usm_pkg::LEN_MIN;
      end
      else if (tx_pop)
      begin
         word_q <= tx_head[DW-1:0];
         // keep or release tag travels with the word
         keep_q <= tx_head[DW];
         len_q  <= eff_len(tx_head[DW-1:0], var_width, shift_len);
      end
   end

   // clock phase and physical output level
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         phase_q          <= 1'b0;
         edge_q           <= '0;
         serial_clock_out <= 1'b0;
      end
      else
      begin
         if (state_q == usm_pkg::USM_LOAD)
         begin
            phase_q <= 1'b0;
            edge_q  <= '0;
         end
         else if (tick && state_q == usm_pkg::USM_SHIFT)
         begin
            phase_q <= ~phase_q;
            edge_q  <= edge_q + 1'b1;
         end
         serial_clock_out <= ((tick && state_q == usm_pkg::USM_SHIFT) ? ~phase_q : phase_q)
                             ^ clk_idle_high;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         tx_sh_q <= '0;
      else if (state_q == usm_pkg::USM_LOAD)
         tx_sh_q <= (var_width && msb_first) ?
                    {word_q[usm_pkg::VDATA_HI:0], usm_pkg::VDATA_PAD'(0)} : word_q;
      else if (out_edge)
         tx_sh_q <= msb_first ? {tx_sh_q[DW-2:0], 1'b0} : {1'b0, tx_sh_q[DW-1:1]};
   end

   // data-out change delayed by the hold count
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mosi_out <= 1'b0;
         pend_q   <= 1'b0;
         hcnt_q   <= '0;
      end
      else if (state_q == usm_pkg::USM_LOAD)
      begin
         mosi_out <= msb_first ? (var_width ? word_q[usm_pkg::VDATA_HI] : word_q[DW-1])
                               : word_q[0];
         hcnt_q   <= '0;
      end
      else if (out_edge && hold_cycles(hold_sel) == '0)
         mosi_out <= next_bit;
      else if (out_edge)
      begin
         pend_q <= next_bit;
         hcnt_q <= hold_cycles(hold_sel);
      end
      else if (hcnt_q != '0)
      begin
         hcnt_q <= hcnt_q - 1'b1;
         if (hcnt_q == 3'h1)
            mosi_out <= pend_q;
      end
   end

   // receive shift register
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_sh_q <= '0;
         first_q <= 1'b1;
      end
      else if (state_q == usm_pkg::USM_LOAD)
      begin
         rx_sh_q <= '0;
         first_q <= 1'b1;
      end
      else
      begin
         if (in_edge)
            first_q <= 1'b0;
         if (sample)
            rx_sh_q <= msb_first ? {rx_sh_q[DW-2:0], miso_q} : {miso_q, rx_sh_q[DW-1:1]};
      end
   end

   // chip-select pattern while active or held by keep_q, all high otherwise
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         cs_n_out <= usm_pkg::CS_IDLE;
      else if (state_q == usm_pkg::USM_LOAD)
         cs_n_out <= (var_cs && var_width) ? word_q[usm_pkg::VCS_HI:usm_pkg::VCS_LO]
                                           : cs_pattern;
      else if (finish && !keep_q)
         cs_n_out <= usm_pkg::CS_IDLE;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_empty_irq <= 1'b1;
         idle_irq     <= 1'b1;
      end
      else
      begin
         tx_empty_irq <= tx_empty;
         idle_irq     <= tx_empty && (state_q == usm_pkg::USM_IDLE) &&
                         (cs_n_out == usm_pkg::CS_IDLE || keep_q);
      end
   end
endmodule : usm_master

/* shared/usm_pkg.sv */
// constants for the universal spi master: fifo shape, transmit word
// fields, hold encodings, state codes. assumes a single system clock.
package usm_pkg;
   localparam int unsigned DATA_W       = 32;
   localparam int unsigned FIFO_DEPTH   = 4;
   localparam int unsigned FIFO_AW      = 2;
   localparam int unsigned LVL_W        = 3;
   localparam int unsigned SPEED_W      = 12;
   localparam int unsigned LEN_W        = 6;
   localparam int unsigned EDGE_W       = 7;
   // variable-mode transmit word fields
   localparam int unsigned VCS_HI       = 31;
   localparam int unsigned VCS_LO       = 29;
   localparam int unsigned VLEN_HI      = 28;
   localparam int unsigned VLEN_LO      = 24;
   localparam int unsigned VDATA_HI     = 23;
   localparam int unsigned VDATA_PAD    = 8;
   // reset values and length limits of the configuration inputs' effect
   localparam logic [2:0]  CS_IDLE      = 3'h7;
   localparam logic [5:0]  LEN_MIN      = 6'h01;
   localparam logic [5:0]  LEN_FULL     = 6'h20;
   // extra data-out hold in system clocks per hold code
   localparam logic [2:0]  HOLD_C0      = 3'h0;
   localparam logic [2:0]  HOLD_C1      = 3'h1;
   localparam logic [2:0]  HOLD_C2      = 3'h4;
   localparam logic [2:0]  HOLD_C3      = 3'h7;
   // half-bit ticks in a full bit-time
   localparam logic [3:0]  HALVES_BIT   = 4'h2;
   typedef enum logic [2:0] {
      USM_IDLE   = 3'h0,
      USM_LOAD   = 3'h1,
      USM_SETUP  = 3'h3,
      USM_SHIFT  = 3'h2,
      USM_TAIL   = 3'h6,
      USM_HOLD   = 3'h7,
      USM_CSHIGH = 3'h5
   } usm_state_t;
endpackage : usm_pkg

/* verilog/usm_fifo.sv */
// small fifo with registered first-word read data and registered flags.
// assumes push is ignored when full and pop when empty.
`timescale 1ns/1ps
module usm_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 4,
   parameter int unsigned AW    = 2,
   parameter int unsigned LW    = 3
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             flush,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] rd_data_q,
   output logic                  empty_q,
   output logic                  full_q,
   output logic      [LW-1:0]    count_q
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW-1:0]    rd_ptr_d;
   logic [LW-1:0]    count_d;
   logic             do_push;
   logic             do_pop;

   assign do_push  = push && !full_q;
   assign do_pop   = pop && !empty_q;
   assign rd_ptr_d = do_pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
   assign count_d  = count_q + LW'(do_push) - LW'(do_pop);

   always_ff @(posedge clk)
   begin
      if (do_push)
         mem_q[wr_ptr_q] <= wr_data;
   end

   // read data comes from a register, bypassing a same-cycle write
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rd_data_q <= '0;
      else if (do_push && wr_ptr_q == rd_ptr_d)
         rd_data_q <= wr_data;
      else
         rd_data_q <= mem_q[rd_ptr_d];
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
         empty_q  <= 1'b1;
         full_q   <= 1'b0;
      end
      else if (flush)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
         empty_q  <= 1'b1;
         full_q   <= 1'b0;
      end
      else
      begin
         wr_ptr_q <= do_push ? wr_ptr_q + 1'b1 : wr_ptr_q;
         rd_ptr_q <= rd_ptr_d;
         count_q  <= count_d;
         empty_q  <= (count_d == '0);
         full_q   <= (count_d == LW'(DEPTH));
      end
   end
endmodule : usm_fifo

/* verilog/usm_tick.sv */
// half-bit tick divider: one pulse every div+1 system clocks while run.
// assumes run drops for at least one cycle to restart the phase.
`timescale 1ns/1ps
module usm_tick #(
   parameter int unsigned W = 12
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         run,
   input  wire logic [W-1:0] div,
   output logic              tick_q
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end
      else if (!run)
      begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end
      else if (cnt_q == div)
      begin
         cnt_q  <= '0;
         tick_q <= 1'b1;
      end
      else
      begin
         cnt_q  <= cnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end
endmodule : usm_tick

/* verification/usm_props.sv */
// port checker for the spi master: flag relations and bit timing.
// assumes the bench runs speed 7; bound to usm_master by name at the end of this file.
`timescale 1ns/1ps
module usm_master_chk (
   input wire logic                        ref_clk,
   input wire logic                        arst_n,
   input wire logic                        enable,
   input wire logic [usm_pkg::SPEED_W-1:0] speed,
   input wire logic                        tx_full,
   input wire logic [usm_pkg::LVL_W-1:0]   tx_level,
   input wire logic                        rx_empty,
   input wire logic [usm_pkg::LVL_W-1:0]   rx_level,
   input wire logic                        tx_empty_irq,
   input wire logic                        idle_irq,
   input wire logic                        serial_clock_out,
   input wire logic [2:0]                  cs_n_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   quiet_off_a: assert property (idle_irq && !enable |=> $stable(serial_clock_out))
      else $error("serial clock moved while disabled");
   cs_setup_a: assert property ($fell(cs_n_out[0]) && speed == 12'h007 |->
      $stable(serial_clock_out) [*8]) else $error("clock edge too soon after select");
   half_bit_a: assert property ($changed(serial_clock_out) && speed == 12'h007 |=>
      $stable(serial_clock_out) [*7]) else $error("serial clock half period short");
   tx_full_a: assert property (tx_full == (tx_level == 3'h4) && tx_level <= 3'h4)
      else $error("transmit full flag wrong");
   rx_level_a: assert property (rx_empty == (rx_level == 3'h0) && rx_level <= 3'h4)
      else $error("receive level and empty disagree");
   // empty flag one cycle behind level
   tx_empty_a: assert property (tx_empty_irq == $past(tx_level == 3'h0))
      else $error("transmit empty flag wrong");
   idle_flag_a: assert property (idle_irq |-> tx_empty_irq && $stable(cs_n_out))
      else $error("idle flag while busy");
   cs_high_a: assert property ($rose(cs_n_out[0]) && speed == 12'h007 |->
      cs_n_out[0] [*8]) else $error("select high time short");
endmodule : usm_master_chk

bind usm_master usm_master_chk usm_master_chk_i (.ref_clk, .arst_n, .enable, .speed,
   .tx_full, .tx_level, .rx_empty, .rx_level, .tx_empty_irq, .idle_irq,
   .serial_clock_out, .cs_n_out);

/* verification/usm_slave.sv */
// spi slave on select 0: samples mosi on rising clock, rotates a word
// out on miso on falling clock. assumes clock idle low.
`timescale 1ns/1ps
module usm_slave #(
   parameter logic [31:0] WORD = 32'hc3a5_5a3c
) (
   input  wire logic sclk,
   input  wire logic mosi,
   input  wire logic cs_n,
   output logic      miso
);
   logic [31:0] sr_q = WORD;
   logic [31:0] cap_q = '0;
   logic        idle_q = 1'b0;
   always @(negedge cs_n)
   begin
      sr_q = WORD;
      cap_q = '0;
   end
   // released line shows the inverse of the last bit
   always @(posedge cs_n) idle_q = ~sr_q[31];
   always @(posedge sclk) if (!cs_n) cap_q = {cap_q[30:0], mosi};
   always @(negedge sclk) if (!cs_n) sr_q = {sr_q[30:0], sr_q[31]};
   assign miso = cs_n ? idle_q : sr_q[31];
endmodule : usm_slave

/* verification/usm_master_tb_top.sv */
// self-checking bench for usm_master with a slave on select 0.
// assumes speed 7 so every hold code fits inside a half bit.
`timescale 1ns/1ps
`define CHK(name, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         fails++; \
         $display("[ERR] %s exp %h got %h", name, exp, got); \
      end \
   end
module usm_master_tb_top;
   localparam logic [31:0] SLV = 32'hc3a5_5a3c;
   logic ref_clk = 1'b0, arst_n = 1'b0, enable = 1'b0, post_input = 1'b0;
   logic [11:0] speed = 12'h007;
   logic [2:0] cs_pattern = 3'h6, cs_high_extra = 3'h0;
   logic var_cs = 1'b0, var_width = 1'b0, in_rising = 1'b1, clear_fifos = 1'b0;
   logic [1:0] hold_sel = 2'h0;
   logic out_rising = 1'b0, clk_idle_high = 1'b0, msb_first = 1'b1;
   logic [5:0] shift_len = 6'h08;
   logic tx_push = 1'b0, tx_keep_cs = 1'b0, rx_pop = 1'b0, miso_in;
   logic [31:0] tx_data = '0, rx_data;
   logic tx_full, rx_empty, tx_empty_irq, idle_irq, serial_clock_out, mosi_out;
   logic [2:0] tx_level, rx_level, cs_n_out;
   int fails = 0, comparisons = 0, cyc = 0, cs_rises = 0, len, k;
   logic [31:0] w;
   logic m;

   usm_master usm_master_i (.ref_clk, .arst_n, .enable, .speed, .cs_pattern, .post_input,
      .var_cs, .var_width, .hold_sel, .in_rising, .clear_fifos, .out_rising, .clk_idle_high,
      .msb_first, .shift_len, .cs_high_extra, .tx_push, .tx_keep_cs, .tx_data, .rx_pop,
      .miso_in, .tx_full, .tx_level, .rx_data, .rx_empty, .rx_level, .tx_empty_irq,
      .idle_irq, .serial_clock_out, .mosi_out, .cs_n_out);
   usm_slave #(.WORD(SLV)) usm_slave_i (.sclk(serial_clock_out), .mosi(mosi_out),
      .cs_n(cs_n_out[0]), .miso(miso_in));

   always #20 ref_clk = ~ref_clk;
   always @(posedge cs_n_out[0]) cs_rises++;
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   task automatic push(input logic [31:0] d, input logic keep);
      @(posedge ref_clk);
      tx_push <= 1'b1;
      tx_data <= d;
      tx_keep_cs <= keep;
      @(posedge ref_clk);
      tx_push <= 1'b0;
   endtask : push

   task automatic wait_idle();
      int n;
      n = 0;
      repeat (4) @(posedge ref_clk);
      while (idle_irq !== 1'b1 && n < 2000)
      begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 2000) fails++;
   endtask : wait_idle

   task automatic pop(input logic [31:0] e, input logic chk);
      repeat (2) @(negedge ref_clk);
      if (chk) `CHK("rx data", e, rx_data)
      @(posedge ref_clk);
      rx_pop <= 1'b1;
      @(posedge ref_clk);
      rx_pop <= 1'b0;
   endtask : pop

   // model: expected mosi stream and slave word for one ending-address burst
   task automatic burst(input logic [31:0] d, input int n, input logic vw, input logic ms,
                        input logic chk);
      logic [31:0] e;
      logic [31:0] r;
      e = '0;
      r = '0;
      // received bits in arrival order, right-aligned for either bit order
      for (int i = 0; i < n; i++)
         r[ms ? n - 1 - i : i] = SLV[31 - i];
      for (int i = 0; i < n; i++)
         e = {e[30:0], ms ? d[(vw ? 23 : 31) - i] : d[i]};
      push(d, 1'b0);
      wait_idle();
      `CHK("mosi word", e, usm_slave_i.cap_q)
      `CHK("rx level", 3'h1, rx_level)
      pop(r, chk);
   endtask : burst

   initial
   begin
      void'($urandom(81614));
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(negedge ref_clk);
      `CHK("cs idle", 3'h7, cs_n_out)
      `CHK("idle flag", 1'b1, idle_irq)
      push(32'h1111_2222, 1'b0);
      push(32'h3333_4444, 1'b0);
      @(negedge ref_clk);
      `CHK("tx level", 3'h2, tx_level)
      @(posedge ref_clk);
      clear_fifos <= 1'b1;
      @(posedge ref_clk);
      clear_fifos <= 1'b0;
      repeat (2) @(negedge ref_clk);
      `CHK("tx flushed", 1'b1, tx_empty_irq)
      // chained words, fifth refused while full
      for (k = 0; k < 5; k++) push(32'h0000_00a0 + k, k > 2 ? 1'b0 : 1'b1);
      repeat (20) @(negedge ref_clk);
      `CHK("tx full", 3'h4, tx_level)
      `CHK("no activity", 4'h7, {serial_clock_out, cs_n_out})
      cs_rises = 0;
      @(posedge ref_clk);
      enable <= 1'b1;
      wait_idle();
      `CHK("one select release", 1, cs_rises)
      `CHK("rx four", 3'h4, rx_level)
      for (k = 0; k < 4; k++) pop((SLV >> (24 - 8 * k)) & 32'h0000_00ff, 1'b1);
      // hold codes with boundary and random lengths
      for (k = 0; k < 4; k++)
      begin
         len = (k == 0) ? 1 : (k == 1) ? 32 : 1 + $urandom % 32;
         m = 1'($urandom % 2);
         @(posedge ref_clk);
         hold_sel <= 2'(k);
         msb_first <= m;
         shift_len <= 6'(len);
         cs_high_extra <= 3'($urandom % 8);
         burst($urandom, len, 1'b0, m, 1'b1);
      end
      len = 1 + $urandom % 24;
      w = {3'h6, 5'(len), 24'($urandom)};
      @(posedge ref_clk);
      var_width <= 1'b1;
      var_cs <= 1'b1;
      cs_pattern <= 3'h7;
      msb_first <= 1'b1;
      burst(w, len, 1'b1, 1'b1, 1'b1);
      @(posedge ref_clk);
      var_width <= 1'b0;
      var_cs <= 1'b0;
      cs_pattern <= 3'h6;
      post_input <= 1'b1;
      shift_len <= 6'h10;
      burst($urandom, 16, 1'b0, 1'b1, 1'b0);
      @(posedge ref_clk);
      clk_idle_high <= 1'b1;
      repeat (3) @(negedge ref_clk);
      `CHK("idle high clock", 1'b1, serial_clock_out)
      // idle-high clock: first edge falls, data still taken on rising
      burst($urandom, 16, 1'b0, 1'b1, 1'b0);
      `CHK("idle high after", 1'b1, serial_clock_out)
      repeat (8) @(posedge ref_clk);
      clk_idle_high <= 1'b0;
      repeat (10) @(posedge ref_clk);
      stop_test();
   end
endmodule : usm_master_tb_top
